// ### common/ric_defines.vh
// constants for the reset and interrupt control block
// assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus
`ifndef RIC_DEFINES_VH
`define RIC_DEFINES_VH
`define RIC_OFS_STATUS 12'h000
`define RIC_OFS_MASK 12'h004
`define RIC_OFS_FLAGS 12'h008
`define RIC_OFS_SENSE 12'h00C
`define RIC_OFS_GIE 12'h010
`define RIC_BIT_POR 0
`define RIC_BIT_EXT 1
`define RIC_BIT_IRQ1 7
`define RIC_BIT_IRQ0 6
`define RIC_CNT_FAST 16'h0400
`define RIC_CNT_SLOW 16'h4000
`define RIC_PIN_FILT_NS 50
`define RIC_CLK_NS 40
`define RIC_PIN_FILT_CYC (((`RIC_PIN_FILT_NS + `RIC_CLK_NS - 1) / `RIC_CLK_NS) + 1)
`define RIC_VEC_RESET 10'h000
`define RIC_VEC_IRQ0 10'h001
`define RIC_VEC_IRQ1 10'h002
`define RIC_SNS_LOW 2'h0
`define RIC_SNS_ANY 2'h1
`define RIC_SNS_FALL 2'h2
`define RIC_SNS_RISE 2'h3
`endif

// ### dv/ric_core_model.sv
// model of the core side: accepts requests, runs a handler, returns
// assumes the same clock as the block; oscillator tick runs free
module ric_core_model (
    input wire clk_i,
    input wire srst_i,
    input wire irq_req_i,
    input wire [9:0] irq_vector_i,
    input wire [3:0] delay_i,
    output logic irq_ack_o,
    output logic return_from_irq_instr_o,
    output wire tick_o,
    output logic [19:0] vec_log_o,
    output logic [3:0] served_o
);
    logic [1:0] osc_r = 2'h0;
    logic [3:0] wait_r;
    logic [3:0] isr_r;
    assign tick_o = osc_r[1];
    // accept after a stall, handler keeps status itself, then return
    always @(posedge clk_i) begin
        osc_r <= osc_r + 2'h1;
        irq_ack_o <= 1'b0;
        return_from_irq_instr_o <= 1'b0;
        if (srst_i) begin
            wait_r <= 4'h0;
            isr_r <= 4'h0;
            served_o <= 4'h0;
            vec_log_o <= 20'h0;
        end else if (isr_r != 4'h0) begin
            isr_r <= isr_r - 4'h1;
            return_from_irq_instr_o <= (isr_r == 4'h1);
        end else if (irq_req_i && wait_r >= delay_i) begin
            irq_ack_o <= 1'b1;
            wait_r <= 4'h0;
            isr_r <= 4'h8;
            served_o <= served_o + 4'h1;
            vec_log_o <= {vec_log_o[9:0], irq_vector_i};
        end else if (irq_req_i) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // ric_core_model

// ### dv/ric_props.sv
// assertions on the ports of ric_top
// assumes one clock, srst_i synchronous active high
module ric_props #(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] FAST_CNT = 16'h0400,
    parameter [CNT_W-1:0] SLOW_CNT = 16'h4000
) (
    input wire core_clk_i,
    input wire srst_i,
    input wire reset_pin_n_i,
    input wire wdt_enable_i,
    input wire wdt_timeout_i,
    input wire irq_ack_i,
    input wire return_from_irq_instr_i,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire core_reset_o,
    input wire [9:0] fetch_addr_o,
    input wire fetch_load_o,
    input wire irq_req_o,
    input wire [9:0] irq_vector_o,
    input wire global_irq_en_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    logic [31:0] rd_addr_r;
    // remember the read address for checking returned data
    always @(posedge core_clk_i) begin
        if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
    end
    a_fetch_zero: assert property (fetch_load_o |-> fetch_addr_o == 10'h000)
        else $error("fetch not at address zero");
    a_pin_resets: assert property (!reset_pin_n_i [*8] |-> ##1 core_reset_o)
        else $error("pin low without reset");
    a_wdt_resets: assert property ($rose(wdt_timeout_i && wdt_enable_i) |-> ##[1:6] core_reset_o)
        else $error("watchdog without reset");
    a_hold_min: assert property ($rose(core_reset_o) |-> core_reset_o [*4])
        else $error("core released too early");
    a_ack_clears_gie: assert property (irq_ack_i && irq_req_o |=> !global_irq_en_o)
        else $error("enable kept after accept");
    a_return_from_irq_instr_sets_gie: assert property (return_from_irq_instr_i && !irq_ack_i && !core_reset_o
        |=> global_irq_en_o)
        else $error("enable not set on return");
    a_req_gated: assert property (irq_req_o |-> global_irq_en_o || $past(global_irq_en_o))
        else $error("request with enable off");
    a_vec_legal: assert property (irq_req_o |-> irq_vector_o inside {10'h001, 10'h002})
        else $error("bad vector");
    a_status_rsvd: assert property (s_axi_rvalid && rd_addr_r[11:0] == 12'h000
        |-> s_axi_rdata[31:2] == 30'h0)
        else $error("status reserved bits set");
    a_mask_rsvd: assert property (s_axi_rvalid && rd_addr_r[11:0] == 12'h004
        |-> s_axi_rdata[5:0] == 6'h00)
        else $error("mask reserved bits set");
    c_fetch: cover property (fetch_load_o);
    c_accept: cover property (irq_req_o && irq_ack_i);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ric_props

bind ric_top ric_props #(.CNT_W(CNT_W), .FAST_CNT(FAST_CNT), .SLOW_CNT(SLOW_CNT)) u_props (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .reset_pin_n_i(reset_pin_n_i), .wdt_enable_i(wdt_enable_i),
    .wdt_timeout_i(wdt_timeout_i), .irq_ack_i(irq_ack_i), .return_from_irq_instr_i(return_from_irq_instr_i),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .core_reset_o(core_reset_o), .fetch_addr_o(fetch_addr_o), .fetch_load_o(fetch_load_o),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .global_irq_en_o(global_irq_en_o));

// ### dv/testbench.sv
// self-checking bench for ric_top with shortened start-up counts
// assumes core model drives ack, return and oscillator tick
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC = 4;
    localparam int SC = 8;
    logic clk = 0, srst = 1, por = 1, pin_n = 0, wen = 0, wto = 0, fuse = 0, p0 = 1, p1 = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, lfsr_r = 32'd37, d;
    logic [3:0] wstrb = 0, dly = 0;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    wire awr, wr, bv, arr, rv, crst, fld, irq, gie, ack, return_from_irq_instr, tick;
    wire [1:0] br, rr;
    wire [31:0] rd;
    wire [9:0] fa, vec;
    wire [19:0] vlog;
    wire [3:0] served;
    int error_cnt = 0, n_checks = 0, n_fetch = 0;
    always #20 clk = ~clk;
    ric_top #(.FAST_CNT(16'h4), .SLOW_CNT(16'h8)) dut (.core_clk_i(clk), .srst_i(srst), .power_on_i(por),
        .reset_pin_n_i(pin_n), .wdt_enable_i(wen), .wdt_timeout_i(wto), .wdt_osc_tick_i(tick),
        .fast_startup_fuse_i(fuse), .ext_irq_zero_pin_i(p0), .ext_irq_one_pin_i(p1), .irq_ack_i(ack),
        .return_from_irq_instr_i(return_from_irq_instr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .core_reset_o(crst),
        .fetch_addr_o(fa), .fetch_load_o(fld), .irq_req_o(irq), .irq_vector_o(vec), .global_irq_en_o(gie));
    ric_core_model u_core (.clk_i(clk), .srst_i(srst), .irq_req_i(irq), .irq_vector_i(vec), .delay_i(dly),
        .irq_ack_o(ack), .return_from_irq_instr_o(return_from_irq_instr), .tick_o(tick), .vec_log_o(vlog), .served_o(served));
    // count restarts of instruction fetch
    always @(negedge clk) if (fld === 1'b1) n_fetch++;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
        logic ah, wh, bh;
        logic [1:0] q;
        int k;
        bh = 0;
        k = 0;
        @(posedge clk);
        awaddr <= {20'h0, a}; wdata <= v; wstrb <= 4'hF; awv <= 1; wv <= 1; bre <= 1;
        while (!bh && k < 200) begin
            @(negedge clk);
            ah = awv && awr; wh = wv && wr; bh = bv && bre; q = br; k++;
            @(posedge clk);
            if (ah) awv <= 0;
            if (wh) wv <= 0;
            if (bh) bre <= 0;
        end
        if (!bh) chk("wr_timeout", 0, 1);
        chk("bresp", {30'h0, q}, 32'h0);
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ah, rh;
        int k;
        rh = 0;
        k = 0;
        @(posedge clk);
        araddr <= {20'h0, a}; arv <= 1; rre <= 1;
        while (!rh && k < 200) begin
            @(negedge clk);
            ah = arv && arr; rh = rv && rre; v = rd; r = rr; k++;
            @(posedge clk);
            if (ah) arv <= 0;
            if (rh) rre <= 0;
        end
        if (!rh) chk("rd_timeout", 0, 1);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [1:0] r;
        axi_rd(a, d, r);
        chk("rdata", d, e);
    endtask
    // wait for the core to be held, then measure the hold in clocks
    task automatic hold_len(input int t);
        int k, n;
        k = 0;
        n = 0;
        while (crst !== 1'b1 && k < 100) begin @(negedge clk); k++; end
        while (crst === 1'b1 && n < 2000) begin @(negedge clk); n++; end
        chk("hold_len", (n >= t * 4 - 4 && n <= t * 4 + 24), 1);
    endtask
    task automatic wait_served(input int s);
        int k;
        k = 0;
        while (served != s && k < 500) begin @(negedge clk); k++; end
    endtask
    // watchdog against hangs
    initial begin
        #2000000;
        error_cnt++;
        final_report();
    end
    // main sequence
    initial begin
        logic [1:0] r;
        repeat (12) @(posedge clk);
        srst <= 0;
        repeat (4) @(posedge clk);
        por <= 0;
        repeat (20) @(posedge clk);
        chk("held_by_pin", crst, 1);
        pin_n <= 1;
        hold_len(SC);
        rd_chk(12'h000, 32'h3);
        axi_wr(12'h000, 32'hFFFFFFFE);
        rd_chk(12'h000, 32'h2);
        axi_wr(12'h000, 32'h1);
        rd_chk(12'h000, 32'h0);
        @(posedge clk) pin_n <= 0;
        repeat (10) @(posedge clk);
        chk("pin_reset", crst, 1);
        pin_n <= 1;
        hold_len(SC);
        rd_chk(12'h000, 32'h2);
        axi_wr(12'h004, 32'hC0);
        @(posedge clk) begin fuse <= 1; wen <= 1; wto <= 1; end
        hold_len(FC);
        @(posedge clk) wto <= 0;
        rd_chk(12'h000, 32'h2);
        rd_chk(12'h004, 32'h0);
        chk("fetch_loads", n_fetch, 3);
        axi_wr(12'h00C, 32'hE);
        @(posedge clk) begin p0 <= 0; p1 <= 1; end
        repeat (8) @(posedge clk);
        rd_chk(12'h008, 32'hC0);
        axi_wr(12'h008, 32'h0);
        rd_chk(12'h008, 32'hC0);
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr(lfsr_r);
            axi_wr(12'h004, lfsr_r);
            rd_chk(12'h004, lfsr_r & 32'hC0);
        end
        chk("no_service", served, 0);
        dly <= lfsr_r[3:0];
        axi_wr(12'h004, 32'hC0);
        axi_wr(12'h010, 32'h1);
        wait_served(2);
        chk("first_vec", vlog[19:10], 1);
        chk("second_vec", vlog[9:0], 2);
        repeat (12) @(posedge clk);
        rd_chk(12'h008, 32'h0);
        rd_chk(12'h010, 32'h1);
        axi_rd(12'h040, d, r);
        chk("unmapped_resp", {30'h0, r}, 32'h2);
        chk("unmapped_data", d, 32'h0);
        axi_wr(12'h010, 32'h0);
        axi_wr(12'h00C, 32'h0);
        @(posedge clk) p0 <= 1;
        @(posedge clk) p0 <= 0;
        repeat (8) @(posedge clk);
        rd_chk(12'h008, 32'h0);
        axi_wr(12'h010, 32'h1);
        wait_served(3);
        @(posedge clk) p0 <= 1;
        chk("level_vec", vlog[9:0], 1);
        repeat (20) @(posedge clk);
        final_report();
    end
endmodule // testbench

// ### verilog/ric_top.v
// reset sequencing, reset cause status and external interrupt acceptance
// assumes watchdog oscillator tick, pins and core handshakes arrive as described on ports
// all logic runs on core_clk_i with srst_i synchronous
// register bus is axi4-lite, byte lane 0 only
//
// Our own choices: the address map and the AXI4-Lite slave port.
`include "ric_defines.vh"

// Function
// RULE_01 - reset pin low beyond 50 ns resets the device, even without clock; here the pin is synced and filtered on core_clk_i, so no clock means no reset
// RULE_02 - enabled watchdog time-out produces a reset
// RULE_03 - during reset registers take initial values; fetch restarts at address zero
// RULE_04 - delay counter ticks on watchdog oscillator, 1K fast, 16K slow
// RULE_05 - after pin release the delay runs; core held until it completes
// RULE_06 - watchdog reset is one clock pulse; delay starts at its end
// RULE_07 - outside circuitry may hold pin low to stretch power-on reset
// RULE_08 - external flag set only by pin reset; watchdog leaves it alone
// RULE_09 - power-on flag set only by power-on reset
// RULE_10 - writing zero clears a status flag; software cannot set them
// RULE_11 - status bits seven to two read zero
// RULE_12 - software reads then clears both flags early after start-up
// RULE_13 - accepting an interrupt clears global enable
// RULE_14 - return from interrupt sets global enable
// RULE_15 - vectoring clears the serviced source's pending flag
// RULE_16 - writing one to a flag clears it; zero leaves it
// RULE_17 - flags set while disabled and retained until serviced or cleared
// RULE_18 - pending flags wait for global enable, then serviced by priority
// RULE_19 - level-sensed interrupt has no latched flag, request only while active
// RULE_20 - status register is not saved or restored on entry or return
// RULE_21 - mask bit seven enables interrupt one, vector two, two sense bits
// RULE_22 - mask bit six enables interrupt zero, vector one; bits five to zero zero
// RULE_23 - lowest vector wins; reset first, then interrupt zero
// RULE_24 - pin activity requests even when pin drives as output
module ric_top #(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] FAST_CNT = `RIC_CNT_FAST,
    parameter [CNT_W-1:0] SLOW_CNT = `RIC_CNT_SLOW
) (
    input wire core_clk_i,
    input wire srst_i,
    input wire power_on_i,
    input wire reset_pin_n_i,
    input wire wdt_enable_i,
    input wire wdt_timeout_i,
    input wire wdt_osc_tick_i,
    input wire fast_startup_fuse_i,
    input wire ext_irq_zero_pin_i,
    input wire ext_irq_one_pin_i,
    input wire irq_ack_i,
    input wire return_from_irq_instr_i,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg core_reset_o,
    output reg [9:0] fetch_addr_o,
    output reg fetch_load_o,
    output reg irq_req_o,
    output reg [9:0] irq_vector_o,
    output reg global_irq_en_o
);
    // sequencer states, one-hot
    // hold: a reset source is still active
    // delay: counting oscillator ticks
    // run: core released and fetching
    localparam ST_HOLD = 3'b001;
    localparam ST_DELAY = 3'b010;
    localparam ST_RUN = 3'b100;

    // edge test for the chosen sense mode
    // mode 0 is level, handled outside this function
    function sense_hit;
        input [1:0] mode;
        input cur;
        input prev;
        begin
            case (mode)
                `RIC_SNS_ANY: sense_hit = cur ^ prev;
                `RIC_SNS_FALL: sense_hit = prev & ~cur;
                `RIC_SNS_RISE: sense_hit = cur & ~prev;
                default: sense_hit = 1'b0;
            endcase
        end
    endfunction

    // synchroniser stages, one pair per outside input
    // nothing but the second stage is read by logic
    // edge detectors look at the second stage only
    reg [1:0] pin_sync_r;
    reg [1:0] wen_sync_r;
    reg [1:0] fuse_sync_r;
    reg [1:0] por_sync_r;
    reg [1:0] wto_sync_r;
    reg [1:0] tick_sync_r;
    reg [1:0] irq0_sync_r;
    reg [1:0] irq1_sync_r;
    // previous synced levels for edge detection
    reg tick_prev_r;
    reg irq0_prev_r;
    reg irq1_prev_r;
    reg wto_prev_r;
    // pin filter count and filtered pin reset
    reg [3:0] filt_cnt_r;
    reg pin_low_r;
    reg wdt_pulse_r;
    // sequencer state and start-up delay count
    reg [2:0] state_r;
    reg [CNT_W-1:0] dly_cnt_r;
    // reset cause flags, cleared by srst_i or by a software zero write
    reg ext_flag_r;
    reg por_flag_r;
    // interrupt mask, sense modes, edge flags and global enable
    reg [7:0] mask_r;
    reg [3:0] sense_r;
    reg flag0_r;
    reg flag1_r;
    reg gie_r;
    // write address and data held until both arrived
    reg aw_held_r;
    reg w_held_r;
    // only the low twelve address bits are decoded
    reg [11:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;

    wire tick_rise = tick_sync_r[1] & ~tick_prev_r;
    // decoded conditions; level mode has no flag,
    // so its request follows the pin directly
    wire lvl0 = (sense_r[1:0] == `RIC_SNS_LOW) & ~irq0_sync_r[1]; // RULE_19
    wire lvl1 = (sense_r[3:2] == `RIC_SNS_LOW) & ~irq1_sync_r[1]; // RULE_19
    wire hit0 = sense_hit(sense_r[1:0], irq0_sync_r[1], irq0_prev_r); // RULE_24
    wire hit1 = sense_hit(sense_r[3:2], irq1_sync_r[1], irq1_prev_r); // RULE_24
    // pending = level request or latched edge flag
    wire pend0 = lvl0 | flag0_r;
    wire pend1 = lvl1 | flag1_r;
    wire en0 = mask_r[`RIC_BIT_IRQ0] & pend0; // RULE_22
    wire en1 = mask_r[`RIC_BIT_IRQ1] & pend1; // RULE_21
    // any reset source holds the core and clears the mask
    wire any_rst = srst_i | por_sync_r[1] | pin_low_r | wdt_pulse_r;
    // the core accepts only a standing request
    wire take = irq_ack_i & irq_req_o & ~core_reset_o;
    // one register write strobe per offset, lane 0 only
    wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire wr_st = wr_go & (aw_addr_r == `RIC_OFS_STATUS) & w_strb_r[0];
    wire wr_mk = wr_go & (aw_addr_r == `RIC_OFS_MASK) & w_strb_r[0];
    wire wr_fl = wr_go & (aw_addr_r == `RIC_OFS_FLAGS) & w_strb_r[0];
    wire wr_sn = wr_go & (aw_addr_r == `RIC_OFS_SENSE) & w_strb_r[0];
    wire wr_ge = wr_go & (aw_addr_r == `RIC_OFS_GIE) & w_strb_r[0];

    // two-stage synchronisers for all outside inputs
    // watchdog enable is synced on its own before gating
    // fuse is synced too, it may change at any time
    always @(posedge core_clk_i) begin
        pin_sync_r <= {pin_sync_r[0], reset_pin_n_i};
        por_sync_r <= {por_sync_r[0], power_on_i};
        wto_sync_r <= {wto_sync_r[0], wdt_timeout_i};
        wen_sync_r <= {wen_sync_r[0], wdt_enable_i};
        fuse_sync_r <= {fuse_sync_r[0], fast_startup_fuse_i};
        tick_sync_r <= {tick_sync_r[0], wdt_osc_tick_i};
        irq0_sync_r <= {irq0_sync_r[0], ext_irq_zero_pin_i};
        irq1_sync_r <= {irq1_sync_r[0], ext_irq_one_pin_i};
        tick_prev_r <= tick_sync_r[1];
        irq0_prev_r <= irq0_sync_r[1];
        irq1_prev_r <= irq1_sync_r[1];
        wto_prev_r <= wto_sync_r[1] & wen_sync_r[1];
    end

    // reset pin filter and one-clock watchdog reset pulse
    // three sustained low samples at 40 ns exceed 50 ns
    // a shorter glitch restarts the count
    // filter runs on the synced level only
    // watchdog pulse lasts one clock; the delay starts after it
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            filt_cnt_r <= 4'h0;
            pin_low_r <= 1'b0;
            wdt_pulse_r <= 1'b0;
        end else begin
            if (pin_sync_r[1]) begin
                filt_cnt_r <= 4'h0;
                pin_low_r <= 1'b0;
            end else if (filt_cnt_r == `RIC_PIN_FILT_CYC - 1) begin
                pin_low_r <= 1'b1; // RULE_01
            end else begin
                filt_cnt_r <= filt_cnt_r + 4'h1;
            end
            wdt_pulse_r <= wto_sync_r[1] & wen_sync_r[1] & ~wto_prev_r; // RULE_02 RULE_06
        end
    end

    // reset sequencer: hold, then count watchdog oscillator ticks
    // every reset source restarts the hold state
    // the count only advances on oscillator rising edges
    // release happens when the count hits the fuse target
    // fetch restarts at the reset vector with a one-clock load
    always @(posedge core_clk_i) begin
        if (any_rst) begin
            state_r <= ST_HOLD; // RULE_05 RULE_07
            dly_cnt_r <= {CNT_W{1'b0}};
            core_reset_o <= 1'b1;
            fetch_load_o <= 1'b0;
            fetch_addr_o <= `RIC_VEC_RESET;
        end else begin
            fetch_load_o <= 1'b0;
            case (state_r)
                ST_HOLD: begin
                    state_r <= ST_DELAY; // RULE_06
                end
                ST_DELAY: begin
                    if (tick_rise) begin
                        dly_cnt_r <= dly_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE_04
                    end
                    if (dly_cnt_r == (fuse_sync_r[1] ? FAST_CNT : SLOW_CNT)) begin
                        state_r <= ST_RUN;
                        core_reset_o <= 1'b0;
                        fetch_load_o <= 1'b1; // RULE_03
                        fetch_addr_o <= `RIC_VEC_RESET;
                    end
                end
                // the run state waits for the next reset
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: state_r <= ST_HOLD;
            endcase
        end
    end

    // reset cause flags; srst or a software zero write clears them, pin and power-on resets just set
    // a pending set beats a software clear in the same cycle
    // power-on value of the external flag is zero here
    // writing one to a status bit leaves it
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            ext_flag_r <= 1'b0;
            por_flag_r <= 1'b0;
        end else begin
            if (por_sync_r[1]) begin
                por_flag_r <= 1'b1; // RULE_09
            end else if (wr_st & ~w_data_r[`RIC_BIT_POR]) begin
                por_flag_r <= 1'b0; // RULE_10
            end
            if (pin_low_r) begin
                ext_flag_r <= 1'b1; // RULE_08
            end else if (wr_st & ~w_data_r[`RIC_BIT_EXT]) begin
                ext_flag_r <= 1'b0; // RULE_10
            end
        end
    end

    // interrupt enables, flags, priority and acceptance
    // mask and sense come back to zero on every reset
    // only mask bits seven and six are kept
    // hardware clear on vectoring, software clear by writing one
    // return from interrupt re-enables, a write sets or clears
    // enable output mirrors the next value of the enable
    // request is registered and dropped at acceptance
    // interrupt zero wins when both are pending and unmasked
    always @(posedge core_clk_i) begin
        if (any_rst) begin
            mask_r <= 8'h00; // RULE_03
            sense_r <= 4'h0;
            flag0_r <= 1'b0;
            flag1_r <= 1'b0;
            gie_r <= 1'b0;
            irq_req_o <= 1'b0;
            irq_vector_o <= `RIC_VEC_RESET;
            global_irq_en_o <= 1'b0;
        end else begin
            if (wr_mk) mask_r <= {w_data_r[7:6], 6'h00}; // RULE_22
            if (wr_sn) sense_r <= w_data_r[3:0];
            // set beats hardware or software clear
            if (sense_r[1:0] == `RIC_SNS_LOW) flag0_r <= 1'b0; // RULE_19
            else if (hit0) flag0_r <= 1'b1; // RULE_17
            else if ((take & irq_vector_o == `RIC_VEC_IRQ0) | (wr_fl & w_data_r[`RIC_BIT_IRQ0]))
                flag0_r <= 1'b0; // RULE_15 RULE_16
            if (sense_r[3:2] == `RIC_SNS_LOW) flag1_r <= 1'b0; // RULE_19
            else if (hit1) flag1_r <= 1'b1; // RULE_17
            else if ((take & irq_vector_o == `RIC_VEC_IRQ1) | (wr_fl & w_data_r[`RIC_BIT_IRQ1]))
                flag1_r <= 1'b0; // RULE_15 RULE_16
            // no status register save here; software owns it
            if (take) gie_r <= 1'b0; // RULE_13 RULE_20
            else if (return_from_irq_instr_i) gie_r <= 1'b1; // RULE_14
            else if (wr_ge) gie_r <= w_data_r[0];
            global_irq_en_o <= take ? 1'b0 : (return_from_irq_instr_i ? 1'b1 : (wr_ge ? w_data_r[0] : gie_r));
            irq_req_o <= gie_r & ~take & (en0 | en1) & ~core_reset_o; // RULE_18
            irq_vector_o <= en0 ? `RIC_VEC_IRQ0 : `RIC_VEC_IRQ1; // RULE_23
        end
    end

    // axi4-lite write channel: take address and data in any order
    // ready pulses one clock after valid is seen
    // the response waits until both halves are held
    // unmapped or unaligned offsets answer slave error
    // bvalid stands until bready is seen
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr[11:0];
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r[11:5] == 7'h00 && aw_addr_r <= `RIC_OFS_GIE
                    && aw_addr_r[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read channel
    // ready pulses once per read, none while data stands
    // unmapped reads return zero with slave error
    // read data stands until rready is seen
    // reading has no side effect on any flag
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr[11:0])
                    `RIC_OFS_STATUS: s_axi_rdata <= {30'h0, ext_flag_r, por_flag_r}; // RULE_11
                    `RIC_OFS_MASK: s_axi_rdata <= {24'h0, mask_r};
                    `RIC_OFS_FLAGS: s_axi_rdata <= {24'h0, flag1_r, flag0_r, 6'h00};
                    `RIC_OFS_SENSE: s_axi_rdata <= {28'h0, sense_r};
                    `RIC_OFS_GIE: s_axi_rdata <= {31'h0, gie_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // ric_top
